// File: design/cs_edge_sync.sv
// module: toggle synchroniser turning link chip-select falls into core pulses
`timescale 1ns/1ps
module cs_edge_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic link_nrst,
  input wire logic cs_n,
  cs_sync_if.link lk,
  cs_sync_if.core cr
);
  logic cs_prev_r;
  logic tog_r;
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic link_fall;

  // link side: detect falling chip select, flip a toggle
  assign link_fall = cs_prev_r & ~cs_n;
  assign lk.toggle = tog_r;
  // the link clock stops between frames, so a raised chip select re-arms
  // the detector at once; a clocked copy would miss every later frame
  always_ff @(posedge link_clk or negedge link_nrst or posedge cs_n) begin
    if (!link_nrst) cs_prev_r <= 1'b1;
    else if (cs_n) cs_prev_r <= 1'b1;
    else cs_prev_r <= 1'b0;
  end
  // toggle flips once per frame start
  always_ff @(posedge link_clk or negedge link_nrst) begin
    if (!link_nrst) tog_r <= 1'b0;
    else tog_r <= tog_r ^ link_fall;
  end

  // core side: two flops, then edge compare on the second and third
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= lk.toggle;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign cr.fall_pulse = s2_r ^ s3_r;
endmodule

// File: design/cs_sync_if.sv
// interface: chip-select event crossing between link and core domains
`timescale 1ns/1ps
interface cs_sync_if;
  logic toggle;
  logic fall_pulse;
  modport link (output toggle);
  modport core (input toggle, output fall_pulse);
endinterface

// File: design/ol_channel.sv
// module: per-channel open-load debounce and fault hold timer
`timescale 1ns/1ps
module ol_channel #(
  parameter int DEB_CYC = protect_pkg::OL_DEB_CYC,
  parameter int HOLD_CYC = protect_pkg::OL_HOLD_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic sw_cmd,
  input wire logic load_open,
  output logic open_fault,
  output logic hold_active
);
  initial begin
    if (DEB_CYC < 1 || HOLD_CYC < 1) $error("ol_channel bad counts");
  end
  logic [31:0] deb_r;
  logic [31:0] hold_r;
  logic cmd_prev_r;
  logic load_prev_r;
  logic open_r;
  logic changed;
  logic stable;

  // restart debounce whenever command or load condition changes
  assign changed = (sw_cmd != cmd_prev_r) || (load_open != load_prev_r);
  assign stable = (deb_r >= 32'(DEB_CYC));
  assign open_fault = open_r;
  assign hold_active = (hold_r != 32'h0);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      deb_r <= 32'h0;
      hold_r <= 32'h0;
      cmd_prev_r <= 1'b0;
      load_prev_r <= 1'b0;
      open_r <= 1'b0;
    end else begin
      cmd_prev_r <= sw_cmd;
      load_prev_r <= load_open;
      if (!enable || changed) deb_r <= 32'h0;
      else if (!stable) deb_r <= deb_r + 32'h1;
      open_r <= enable && stable && load_open;
      if (enable && stable && load_open) hold_r <= 32'(HOLD_CYC);
      else if (hold_r != 32'h0) hold_r <= hold_r - 32'h1;
    end
  end
endmodule

// File: design/output_channel_protection_diagnostics.sv
// module: output control, protection, watchdog and led matrix for 8 channels
// Contract
// - lower pairing joins 1-2 and 3-4, from inputs 1 and 3, no push-pull
// - upper pairing joins 5-6 and 7-8, from inputs 5 and 7, no push-pull
// - pairing bits live in serial configuration register 3
// - fault detection and reporting stay per channel when paired
// - open-load enabled by channel bit or global select in serial mode
// - open-load only in high-side mode, switch on or off
// - open-load result reported only after debounce of command and load
// - open load sets fault bit, lights fault led and fault out 200ms
// - watchdog runs only in serial mode with enable input high
// - each chip-select fall restarts watchdog; controller must transfer
// - expiry turns all outputs off, fault low until next cs fall
// - timeout select 00 0.9s, 01 0.45s, 10 0.15s, reset 0.9s
// - overheated driver goes off, high impedance, resumes after hysteresis
// - driver thermal shutdown sets fault out, fault bit and fault led
// - chip over-temperature asserts fault out and shuts all channels
// - one channel fault does not stop the other channels
// - any supply low three-states outputs and open-load sources, readable
// - drive open-drain main supply undervoltage indicator
// - 16 leds in 4x4 matrix, one led per column at once
// - lit fault led forces that channel's level led off
// - every lit led pulsed at 25% duty
// - reduced variant rejects serial config writes in parallel mode
// - enable low turns outputs off, three-states, leds off
// - serial select chooses serial or pin setting, readback unaffected
`timescale 1ns/1ps
module output_channel_protection_diagnostics #(
  parameter int NCH = protect_pkg::NCH,
  parameter bit REDUCED_VARIANT = 1'b0,
  parameter int WD0_CYC = protect_pkg::WD_T0_CYC,
  parameter int WD1_CYC = protect_pkg::WD_T1_CYC,
  parameter int WD2_CYC = protect_pkg::WD_T2_CYC,
  parameter int OL_HOLD_CYC = protect_pkg::OL_HOLD_CYC,
  parameter int OL_DEB_CYC = protect_pkg::OL_DEB_CYC,
  parameter int LED_PHASE_CYC = protect_pkg::LED_PHASE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic serial_setting_select,
  input wire logic output_enable,
  input wire logic push_pull_select,
  input wire logic global_open_load_select,
  input wire logic watchdog_enable_input,
  input wire logic [7:0] par_in,
  input wire logic [7:0] ser_out_set,
  input wire logic [7:0] ser_push_pull,
  input wire logic [7:0] ser_open_load_en,
  input wire logic [7:0] reg3_wdata,
  input wire logic reg3_we,
  input wire logic [7:0] load_open,
  input wire logic [7:0] driver_thermal_limit,
  input wire logic chip_thermal_limit,
  input wire logic uv_vdd,
  input wire logic uv_v5,
  input wire logic uv_vl,
  output logic [7:0] hs_on,
  output logic [7:0] ls_on,
  output logic [7:0] out_hiz,
  output logic [7:0] ol_source_en,
  output logic [7:0] diag_fault,
  output logic [2:0] uv_status,
  output logic [7:0] reg3_rdata,
  output logic fault_n_oe,
  output logic watchdog_fault_output_oe,
  output logic undervoltage_indicator_oe,
  output logic [3:0] led_row,
  output logic [3:0] led_col
);
  initial begin
    if (NCH != 8) $error("block serves exactly eight channels");
    if (WD0_CYC < 1 || WD1_CYC < 1 || WD2_CYC < 1 || LED_PHASE_CYC < 1)
      $error("bad timing counts");
  end

  //--------------------------------------------------------------
  // input synchronisers
  //--------------------------------------------------------------
  logic [31:0] s1_r;
  logic [31:0] s2_r;
  logic [31:0] pin_raw;
  assign pin_raw = {load_open, driver_thermal_limit, par_in,
                    serial_setting_select, output_enable, push_pull_select,
                    global_open_load_select, watchdog_enable_input,
                    chip_thermal_limit, uv_vdd, uv_v5};
  // pins come from outside the clock domain: two flops first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 32'h0;
      s2_r <= 32'h0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
    end
  end
  // vl undervoltage has a synchroniser pair of its own beside the bus
  logic vl_s1_r;
  logic vl_s2_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vl_s1_r <= 1'b0;
      vl_s2_r <= 1'b0;
    end else begin
      vl_s1_r <= uv_vl;
      vl_s2_r <= vl_s1_r;
    end
  end

  wire [7:0] load_s = s2_r[31:24];
  wire [7:0] tl_s = s2_r[23:16];
  wire [7:0] in_s = s2_r[15:8];
  wire ser_s = s2_r[7];
  wire en_s = s2_r[6];
  wire pp_s = s2_r[5];
  wire gol_s = s2_r[4];
  wire wden_s = s2_r[3];
  wire chip_hot = s2_r[2];
  wire uv_vdd_s = s2_r[1];
  wire uv_v5_s = s2_r[0];
  wire uv_any = uv_vdd_s | uv_v5_s | vl_s2_r;

  //--------------------------------------------------------------
  // register 3: pairing and watchdog timeout
  //--------------------------------------------------------------
  logic pair_lower_channels_r;
  logic pair_upper_channels_r;
  logic [1:0] watchdog_timeout_select_r;
  // reduced variant refuses configuration in parallel setting mode
  wire cfg_wr_ok = reg3_we & ~(REDUCED_VARIANT & ~ser_s);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pair_lower_channels_r <= 1'b0;
      pair_upper_channels_r <= 1'b0;
      watchdog_timeout_select_r <= protect_pkg::WD_SEL_RST;
    end else if (cfg_wr_ok) begin
      pair_lower_channels_r <= reg3_wdata[protect_pkg::REG3_PAIR_LO_BIT];
      pair_upper_channels_r <= reg3_wdata[protect_pkg::REG3_PAIR_HI_BIT];
      watchdog_timeout_select_r <=
        reg3_wdata[protect_pkg::REG3_WD_LSB +: 2];
    end
  end

  //--------------------------------------------------------------
  // channel command and mode with pairing
  //--------------------------------------------------------------
  wire [7:0] src_cmd = ser_s ? ser_out_set : in_s;
  logic [7:0] cmd;
  logic [7:0] pp_mode;
  // paired followers copy their leader; no push-pull on paired channels
  assign cmd[0] = src_cmd[0];
  assign cmd[1] = pair_lower_channels_r ? src_cmd[0] : src_cmd[1];
  assign cmd[2] = src_cmd[2];
  assign cmd[3] = pair_lower_channels_r ? src_cmd[2] : src_cmd[3];
  assign cmd[4] = src_cmd[4];
  assign cmd[5] = pair_upper_channels_r ? src_cmd[4] : src_cmd[5];
  assign cmd[6] = src_cmd[6];
  assign cmd[7] = pair_upper_channels_r ? src_cmd[6] : src_cmd[7];
  wire [7:0] pair_mask = {{4{pair_upper_channels_r}},
                          {4{pair_lower_channels_r}}};
  wire [7:0] pp_req = ser_s ? (ser_push_pull | {8{pp_s}}) : {8{pp_s}};
  assign pp_mode = pp_req & ~pair_mask;

  //--------------------------------------------------------------
  // watchdog
  //--------------------------------------------------------------
  cs_sync_if csif ();
  cs_edge_sync u_cs (
    .clk(clk),
    .nrst(nrst),
    .link_clk(spi_clk),
    .link_nrst(nrst),
    .cs_n(cs_n),
    .lk(csif.link),
    .cr(csif.core)
  );
  wire cs_fall = csif.fall_pulse;
  wire wd_active = ser_s & wden_s;
  wire [31:0] wd_limit =
    (watchdog_timeout_select_r == protect_pkg::WD_SEL_0P45) ? 32'(WD1_CYC) :
    (watchdog_timeout_select_r == protect_pkg::WD_SEL_0P15) ? 32'(WD2_CYC) :
    32'(WD0_CYC);
  logic [31:0] wd_cnt_r;
  logic wd_fault_r;
  wire wd_expire = wd_active & ~wd_fault_r & (wd_cnt_r >= wd_limit - 32'h1);
  // count restarts on every cs fall; fault holds until the next fall or until the watchdog leaves serial enable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wd_cnt_r <= 32'h0;
      wd_fault_r <= 1'b0;
    end else begin
      if (!wd_active || cs_fall) wd_cnt_r <= 32'h0;
      else if (!wd_fault_r) wd_cnt_r <= wd_cnt_r + 32'h1;
      if (cs_fall || !wd_active) wd_fault_r <= 1'b0;
      else if (wd_expire) wd_fault_r <= 1'b1;
    end
  end

  //--------------------------------------------------------------
  // open-load channels
  //--------------------------------------------------------------
  logic [7:0] ol_fault;
  logic [7:0] ol_hold;
  // high-side only; enabled per channel or globally in serial mode
  wire [7:0] ol_en = (ser_open_load_en | {8{ser_s & gol_s}})
                     & ~pp_mode & {8{~uv_any}};
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ol
      ol_channel #(.DEB_CYC(OL_DEB_CYC), .HOLD_CYC(OL_HOLD_CYC)) u_ol (
        .clk(clk),
        .nrst(nrst),
        .enable(ol_en[g]),
        .sw_cmd(cmd[g]),
        .load_open(load_s[g]),
        .open_fault(ol_fault[g]),
        .hold_active(ol_hold[g])
      );
    end
  endgenerate

  //--------------------------------------------------------------
  // protection and output drive
  //--------------------------------------------------------------
  // thermal off only counted while vdd is healthy; per channel
  wire [7:0] th_off = tl_s & {8{~uv_vdd_s}};
  wire all_off = chip_hot | wd_fault_r | ~en_s | uv_any;
  wire [7:0] drv_ok = ~th_off & {8{~all_off}};
  wire [7:0] fault_led = th_off | ol_hold;
  wire fault_any = (|th_off) | (|ol_hold) | chip_hot;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hs_on <= 8'h00;
      ls_on <= 8'h00;
      out_hiz <= 8'hFF;
      ol_source_en <= 8'h00;
      diag_fault <= 8'h00;
      uv_status <= 3'h0;
      fault_n_oe <= 1'b0;
      watchdog_fault_output_oe <= 1'b0;
      undervoltage_indicator_oe <= 1'b0;
    end else begin
      hs_on <= cmd & drv_ok;
      ls_on <= ~cmd & pp_mode & drv_ok;
      // high impedance in undervoltage, overheat, watchdog fault or enable low
      out_hiz <= ~drv_ok;
      ol_source_en <= ol_en & ~cmd;
      diag_fault <= th_off | ol_fault | ol_hold;
      uv_status <= {vl_s2_r, uv_v5_s, uv_vdd_s};
      fault_n_oe <= fault_any;
      watchdog_fault_output_oe <= wd_fault_r;
      undervoltage_indicator_oe <= uv_vdd_s;
    end
  end
  // readback of register 3 fields, one cycle after a write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) reg3_rdata <= 8'h00;
    else reg3_rdata <= {4'h0, watchdog_timeout_select_r,
                        pair_upper_channels_r, pair_lower_channels_r};
  end

  //--------------------------------------------------------------
  // led matrix scan
  //--------------------------------------------------------------
  logic [31:0] ph_cnt_r;
  logic [1:0] phase_r;
  // rows 0,1: level leds ch1-4, ch5-8; rows 2,3: fault leds
  wire [7:0] level_led = cmd & ~fault_led;
  wire [15:0] led_on = {fault_led, level_led} & {16{en_s}};
  wire [3:0] row_bits = led_on[phase_r*4 +: 4];
  wire phase_end = (ph_cnt_r == 32'(LED_PHASE_CYC) - 32'h1);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_cnt_r <= 32'h0;
      phase_r <= 2'h0;
      led_row <= 4'h0;
      led_col <= 4'h0;
    end else begin
      ph_cnt_r <= phase_end ? 32'h0 : ph_cnt_r + 32'h1;
      if (phase_end) phase_r <= phase_r + 2'h1;
      led_row <= 4'h1 << phase_r;
      led_col <= row_bits;
    end
  end

  //--------------------------------------------------------------
  // assertions
  //--------------------------------------------------------------
  a_row_onehot: assert property (@(posedge clk) disable iff (!nrst)
    $onehot(led_row) || led_row == 4'h0)
    else $error("more than one led row active");
  a_pair_low_follow: assert property (@(posedge clk) disable iff (!nrst)
    pair_lower_channels_r |-> (cmd[1] == cmd[0] && !pp_mode[1]))
    else $error("lower pair not following leader");
  a_pair_up_follow: assert property (@(posedge clk) disable iff (!nrst)
    pair_upper_channels_r |-> (cmd[7] == cmd[6] && !pp_mode[5]))
    else $error("upper pair not following leader");
  a_wd_outputs_off: assert property (@(posedge clk) disable iff (!nrst)
    wd_fault_r |=> hs_on == 8'h00)
    else $error("outputs on during watchdog fault");
  a_wd_fault_clear: assert property (@(posedge clk) disable iff (!nrst)
    cs_fall |=> !wd_fault_r)
    else $error("watchdog fault not cleared by cs fall");
  a_wd_needs_mode: assert property (@(posedge clk) disable iff (!nrst)
    !wd_active |=> !wd_fault_r)
    else $error("watchdog fault outside serial enable");
  a_uv_hiz: assert property (@(posedge clk) disable iff (!nrst)
    uv_any |=> out_hiz == 8'hFF && ol_source_en == 8'h00)
    else $error("outputs driven under undervoltage");
  a_chip_hot_off: assert property (@(posedge clk) disable iff (!nrst)
    chip_hot |=> hs_on == 8'h00 && fault_n_oe)
    else $error("chip overheat not shutting down");
  a_led_level_off: assert property (@(posedge clk) disable iff (!nrst)
    (fault_led & level_led) == 8'h00)
    else $error("level led lit with fault led");
  a_en_low_dark: assert property (@(posedge clk) disable iff (!nrst)
    !en_s |=> led_col == 4'h0 && hs_on == 8'h00)
    else $error("enable low not honoured");
  a_uv_indicator: assert property (@(posedge clk) disable iff (!nrst)
    uv_vdd_s |=> undervoltage_indicator_oe)
    else $error("undervoltage indicator missing");
  a_th_fault_bit: assert property (@(posedge clk) disable iff (!nrst)
    (th_off[0] && !uv_vdd_s) |=> diag_fault[0] && fault_n_oe)
    else $error("thermal fault not reported");
  a_cfg_readback: assert property (@(posedge clk) disable iff (!nrst)
    cfg_wr_ok |=> ##1 reg3_rdata[3:0] == $past(reg3_wdata[3:0], 2))
    else $error("register 3 write not read back");
  a_pp_pair_off: assert property (@(posedge clk) disable iff (!nrst)
    pair_lower_channels_r |=> ls_on[3:0] == 4'h0)
    else $error("push-pull left on a paired channel");
  a_th_spare: assert property (@(posedge clk) disable iff (!nrst)
    (th_off[0] && !th_off[1] && !all_off && cmd[1]) |=> hs_on[1])
    else $error("healthy channel stopped by neighbour overheat");
  a_wd_limit_hit: assert property (@(posedge clk) disable iff (!nrst)
    $rose(wd_fault_r) |-> $past(wd_cnt_r) >= $past(wd_limit) - 32'h1)
    else $error("watchdog expired before its timeout");
  a_ol_hold_flag: assert property (@(posedge clk) disable iff (!nrst)
    (|ol_hold) |=> fault_n_oe)
    else $error("open-load hold without global fault");
  a_scan_step: assert property (@(posedge clk) disable iff (!nrst)
    phase_end |=> phase_r == $past(phase_r) + 2'h1)
    else $error("led scan skipped a phase");
endmodule

// File: design/protect_pkg.sv
// package: constants for the output channel protection and diagnostics block
package protect_pkg;
  localparam int NCH = 8;
  localparam int CLK_MHZ = 50;
  // hold time of an open-load fault indication, in ms
  localparam int OL_HOLD_MS = 200;
  localparam int OL_HOLD_CYC = OL_HOLD_MS * CLK_MHZ * 1000;
  // watchdog timeouts in ms
  localparam int WD_T0_MS = 900;
  localparam int WD_T1_MS = 450;
  localparam int WD_T2_MS = 150;
  localparam int WD_T0_CYC = WD_T0_MS * CLK_MHZ * 1000;
  localparam int WD_T1_CYC = WD_T1_MS * CLK_MHZ * 1000;
  localparam int WD_T2_CYC = WD_T2_MS * CLK_MHZ * 1000;
  // open-load debounce time, in us
  localparam int OL_DEB_US = 100;
  localparam int OL_DEB_CYC = OL_DEB_US * CLK_MHZ;
  // led scan phase length, in us
  localparam int LED_PHASE_US = 1000;
  localparam int LED_PHASE_CYC = LED_PHASE_US * CLK_MHZ;
  // watchdog timeout select codes and reset value
  localparam logic [1:0] WD_SEL_0P9 = 2'h0;
  localparam logic [1:0] WD_SEL_0P45 = 2'h1;
  localparam logic [1:0] WD_SEL_0P15 = 2'h2;
  localparam logic [1:0] WD_SEL_RST = 2'h0;
  // serial configuration register 3 field positions
  localparam int REG3_PAIR_LO_BIT = 0;
  localparam int REG3_PAIR_HI_BIT = 1;
  localparam int REG3_WD_LSB = 2;
  localparam int LED_ROWS = 4;
endpackage

// File: sim/spi_ctrl_model.sv
// partner: serial controller model making chip-select frames and link clock
`timescale 1ns/1ps
module spi_ctrl_model (
  input wire logic go,
  output logic spi_clk,
  output logic cs_n
);
  // ----------------------------------------
  // frame generator
  // ----------------------------------------
  // link clock idles low and only runs inside a frame
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
  end
  // one request frames one byte, which restarts the watchdog
  always @(posedge go) begin
    #7;
    cs_n = 1'b0;
    repeat (8) begin
      #24;
      spi_clk = 1'b1;
      #24;
      spi_clk = 1'b0;
    end
    #24;
    cs_n = 1'b1;
  end
endmodule

// File: sim/tb_top.sv
// testbench: drives the protection block and checks it through a note queue
`timescale 1ns/1ps
`define CHK(o, e) begin \
  total_checks++; \
  if ((o) !== (e)) begin \
    error_cnt++; \
    $display("mismatch t=%0t got %h exp %h", $time, o, e); \
  end \
end
module tb_top;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  typedef struct packed {logic [3:0] sel; logic [7:0] exp;} note_type;
  logic clk, nrst, go, spi_clk, cs_n, ser, oen, pp, gol, wden, we, cht;
  logic uvd, uv5, uvl;
  logic [7:0] par_in, sos, spp, sol, wd, lo, dtl, aux;
  logic [7:0] hs_on, ls_on, out_hiz, ol_en, diag, rd;
  logic [2:0] uv_status;
  logic flt_oe, wd_oe, uv_oe;
  logic [3:0] led_row, led_col;
  logic [31:0] rs;
  int error_cnt, total_checks, cyc_cnt, i;
  note_type notes[$];
  note_type n;
  // short counts keep the run small; expectations follow these values
  output_channel_protection_diagnostics #(.WD0_CYC(50), .WD1_CYC(30),
    .WD2_CYC(10), .OL_HOLD_CYC(20), .OL_DEB_CYC(5), .LED_PHASE_CYC(4)) dut (
    .clk(clk), .nrst(nrst), .spi_clk(spi_clk), .cs_n(cs_n),
    .serial_setting_select(ser), .output_enable(oen),
    .push_pull_select(pp), .global_open_load_select(gol),
    .watchdog_enable_input(wden), .par_in(par_in), .ser_out_set(sos),
    .ser_push_pull(spp), .ser_open_load_en(sol), .reg3_wdata(wd),
    .reg3_we(we), .load_open(lo), .driver_thermal_limit(dtl),
    .chip_thermal_limit(cht), .uv_vdd(uvd), .uv_v5(uv5), .uv_vl(uvl),
    .hs_on(hs_on), .ls_on(ls_on), .out_hiz(out_hiz), .ol_source_en(ol_en),
    .diag_fault(diag), .uv_status(uv_status), .reg3_rdata(rd),
    .fault_n_oe(flt_oe), .watchdog_fault_output_oe(wd_oe),
    .undervoltage_indicator_oe(uv_oe), .led_row(led_row),
    .led_col(led_col));
  spi_ctrl_model partner (.go(go), .spi_clk(spi_clk), .cs_n(cs_n));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [7:0] obs(input logic [3:0] s);
    case (s)
      4'h0: return hs_on;
      4'h1: return ls_on;
      4'h2: return out_hiz;
      4'h3: return diag;
      4'h4: return rd;
      4'h5: return {flt_oe, wd_oe, 6'h00};
      4'h6: return {uv_oe, 4'h0, uv_status};
      4'h7: return ol_en;
      4'h8: return {4'h0, led_col};
      default: return aux;
    endcase
  endfunction
  task automatic note(input logic [3:0] s, input logic [7:0] e);
    notes.push_back('{s, e});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // register 3 write is a one-cycle strobe; the wait lets it settle
  task automatic wr3(input logic [7:0] v);
    @(posedge clk);
    wd <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    cyc(6);
  endtask
  // bounded wait for the watchdog pin to reach a level
  task automatic wait_wd(input logic v);
    int k;
    k = 0;
    while (wd_oe !== v && k < 300) begin
      @(posedge clk);
      k++;
    end
    if (k == 300) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, wd_oe, v);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // monitor and timeout
  // ----------------------------------------
  // settled values are read mid-cycle, away from the launching edge
  always @(negedge clk) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      `CHK(obs(n.sel), n.exp)
    end
  end
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    {nrst, go, ser, pp, gol, wden, we, cht, uvd, uv5, uvl} = 11'h000;
    {par_in, sos, spp, sol, wd, lo, dtl, aux} = 64'h0;
    oen = 1'b1;
    rs = 32'h0000AD34;
    cyc(6);
    note(4'h2, 8'hFF);
    note(4'h4, 8'h00);
    nrst <= 1'b1;
    cyc(3);
    ser <= 1'b1;
    rs = xs(rs);
    sos <= rs[7:0];
    cyc(6);
    note(4'h0, rs[7:0]);
    ser <= 1'b0;
    rs = xs(rs);
    par_in <= rs[7:0];
    cyc(6);
    note(4'h0, rs[7:0]);
    ser <= 1'b1;
    sos <= 8'h05;
    wr3(8'h01);
    note(4'h0, 8'h0F);
    sos <= 8'h50;
    wr3(8'h02);
    note(4'h0, 8'hF0);
    note(4'h4, 8'h02);
    pp <= 1'b1;
    sos <= 8'h00;
    wr3(8'h01);
    note(4'h1, 8'hF0);
    // open load: none in push-pull, then debounced and held once high-side
    gol <= 1'b1;
    lo <= 8'h20;
    cyc(20);
    note(4'h3, 8'h00);
    pp <= 1'b0;
    wr3(8'h00);
    cyc(20);
    note(4'h3, 8'h20);
    note(4'h5, 8'h80);
    lo <= 8'h00;
    cyc(8);
    note(4'h5, 8'h80);
    cyc(40);
    sos <= 8'hFF;
    dtl <= 8'h04;
    cyc(6);
    note(4'h0, 8'hFB);
    note(4'h2, 8'h04);
    note(4'h3, 8'h04);
    dtl <= 8'h00;
    cyc(6);
    note(4'h0, 8'hFF);
    for (i = 0; i < 16; i++) begin
      @(negedge clk);
      aux = aux | {4'h0, led_row};
      if (!$onehot(led_row)) aux[7] = 1'b1;
    end
    note(4'h9, 8'h0F);
    // back onto the rising edge before driving again
    cyc(1);
    cht <= 1'b1;
    cyc(6);
    note(4'h0, 8'h00);
    note(4'h5, 8'h80);
    cht <= 1'b0;
    uv5 <= 1'b1;
    cyc(6);
    note(4'h2, 8'hFF);
    note(4'h7, 8'h00);
    note(4'h6, 8'h02);
    uv5 <= 1'b0;
    uvd <= 1'b1;
    cyc(6);
    note(4'h6, 8'h81);
    uvd <= 1'b0;
    uvl <= 1'b1;
    cyc(6);
    note(4'h6, 8'h04);
    note(4'h2, 8'hFF);
    uvl <= 1'b0;
    oen <= 1'b0;
    cyc(6);
    note(4'h0, 8'h00);
    note(4'h8, 8'h00);
    oen <= 1'b1;
    gol <= 1'b0;
    // per-channel open-load enable, then per-channel push-pull masks it
    sol <= 8'h03;
    sos <= 8'hFE;
    cyc(6);
    note(4'h7, 8'h01);
    spp <= 8'h01;
    cyc(6);
    note(4'h1, 8'h01);
    note(4'h7, 8'h00);
    // watchdog with the shortest timeout, then a frame clears the fault
    wr3(8'h08);
    wden <= 1'b1;
    cyc(8);
    note(4'h5, 8'h00);
    cyc(8);
    note(4'h5, 8'h40);
    note(4'h0, 8'h00);
    go <= 1'b1;
    wait_wd(1'b0);
    note(4'h5, 8'h00);
    go <= 1'b0;
    wden <= 1'b0;
    cyc(100);
    note(4'h5, 8'h00);
    cyc(4);
    conclude();
  end
endmodule
